// ### include/sfsr_regs.svh
/*
 * register map, field positions and timing counts of the status/fault block.
 * assumes byte addresses on a 32-bit Avalon-MM slave port.
 */
`ifndef SFSR_REGS_SVH
`define SFSR_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SFSR_OFF_LIVE   5'h00
`define SFSR_OFF_STICKY 5'h04
`define SFSR_OFF_ENABLE 5'h08
`define SFSR_OFF_FAULT  5'h0C
`define SFSR_OFF_CTRL   5'h10
`define SFSR_OFF_SPOLL  5'h14
`define SFSR_OFF_CODE   5'h18
`define SFSR_OFF_TEST   5'h1C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SFSR_CTRL_SRQ_EN   0
`define SFSR_CTRL_REINIT   1
`define SFSR_COND_PROG     7
`define SFSR_SP_POWERUP    1
`define SFSR_SP_PROG       2
`define SFSR_SP_SUMMARY    3
`define SFSR_SP_RQS        6
`define SFSR_TEST_SUBSET   8
`define SFSR_CODE_NONE     4'h0
`define SFSR_CODE_NOQUERY  4'h8
`define SFSR_ENABLE_RST    9'h000
`define SFSR_TERM_CHAR     8'h0A

// ----------------------------------------
// timing
// ----------------------------------------
`define SFSR_SETTLE_MS     500
`define SFSR_CLK_KHZ       50000
`define SFSR_SETTLE_CYC    (`SFSR_SETTLE_MS * `SFSR_CLK_KHZ)

`endif

// ### include/sfsr_pkg.sv
/*
 * types shared by the status/fault block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sfsr_pkg;

    typedef logic [8:0] sfsr_cond_t;

    typedef enum logic [1:0] {
        SFSR_IDLE   = 2'b00,
        SFSR_SETTLE = 2'b01,
        SFSR_ACK    = 2'b10
    } sfsr_state_e;

endpackage : sfsr_pkg

// ### hw/sfsr_settle_timer.sv
/*
 * settle timer: busy for a fixed number of cycles after a start pulse.
 * assumes start only arrives while idle.
 */
`timescale 1ns/10ps
module sfsr_settle_timer #(
    parameter int CYC = 25000000
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // control
    input  wire logic start_i,
    output logic      done_o
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         last_w;

    assign last_w = run_q && (cnt_q == W'(1));
    assign cnt_d  = start_i ? W'(CYC) :
                    run_q   ? cnt_q - W'(1) : cnt_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            run_q  <= start_i | (run_q & ~last_w);
            done_o <= last_w;
        end
    end

endmodule : sfsr_settle_timer

// ### hw/sfsr_char_guard.sv
/*
 * command character gate: after a parse fault drops characters up to the
 * next terminator. assumes one character per valid cycle from the bus side.
 */
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module sfsr_char_guard (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    // incoming characters
    input  wire logic       chr_valid_i,
    input  wire logic [7:0] chr_data_i,
    input  wire logic       chr_eoi_i,
    // parser feedback
    input  wire logic       parse_fault_i,
    // filtered characters
    output logic            chr_valid_o,
    output logic [7:0]      chr_data_o,
    output logic            flush_o
);
    logic drop_q;
    logic term_w;

    assign term_w = chr_valid_i &&
                    (chr_eoi_i || chr_data_i == `SFSR_TERM_CHAR);

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drop_q      <= 1'b0;
            chr_valid_o <= 1'b0;
            chr_data_o  <= 8'h00;
            flush_o     <= 1'b0;
        end else begin
            // a fault in the terminator's own cycle still drops onward
            drop_q      <= parse_fault_i | (drop_q & ~term_w);
            chr_valid_o <= chr_valid_i & ~drop_q & ~parse_fault_i;
            chr_data_o  <= chr_data_i;
            flush_o     <= parse_fault_i;
        end
    end

endmodule : sfsr_char_guard

// ### hw/sfsr_status_fault.sv
/*
 * status reporting and fault signalling block: live, sticky, enable and
 * fault registers, serial poll byte, service request, programming fault
 * code, clear sequence and self-test entry, over an Avalon-MM slave.
 * assumes condition inputs synchronous to core_clk_i; text parsing of
 * commands sits outside and talks through the character and fault ports.
 */
// Register access over Avalon-MM and the register offsets were decided locally.
// How it works
// - nine live condition bits, weights one to 256
// - sticky bit remembers any one since read
// - sticky read reloads sticky from live
// - enabled condition rise sets fault bit
// - any fault bit sets summary poll bit
// - enabling already-true condition sets fault bit
// - enable write takes weight sum; zero clears
// - name list, comma separated, any order
// - enable mask never alters live conditions
// - enable query returns mask weight sum
// - fault read returns sum, then clears
// - request raised on summary bit rising
// - request-enable (control) query answers flag as 0/1
// - power-on request by switch; power-up poll bit set at reset
// - clear restores power-on state, presets kept; here power-up poll bit is cleared and self-test result kept
// - clear completes only after settle time
// - parse fault sets bit, lamp, poll
// - after fault drop characters until terminator
// - fault code query returns 0 to 8
// - codes one to four for syntax faults
// - codes five to seven for range faults
// - talk without query records code eight
// - self-test subset follows output enable
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module sfsr_status_fault #(
    parameter int SETTLE_CYC = `SFSR_SETTLE_CYC
) (
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // instrument conditions
    input  wire sfsr_pkg::sfsr_cond_t cond_i,
    input  wire logic              out_en_i,
    input  wire logic              pon_srq_sw_i,
    input  wire logic              dev_clear_i,
    // command characters and parser
    input  wire logic              chr_valid_i,
    input  wire logic [7:0]        chr_data_i,
    input  wire logic              chr_eoi_i,
    input  wire logic              parse_fault_i,
    input  wire logic [3:0]        parse_code_i,
    input  wire logic              talk_no_query_i,
    output logic                   chr_valid_o,
    output logic [7:0]             chr_data_o,
    output logic                   flush_o,
    // self test
    input  wire logic [4:0]        test_code_i,
    output logic                   test_run_o,
    output logic                   test_subset_o,
    // bus and panel
    output logic                   srq_o,
    output logic                   fault_led_o,
    output logic                   reinit_o
);
    import sfsr_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    sfsr_state_e state_q;
    sfsr_state_e state_d;
    sfsr_cond_t  sticky_q;
    sfsr_cond_t  enable_q;
    sfsr_cond_t  fault_q;
    sfsr_cond_t  live_prev_q;
    sfsr_cond_t  enable_prev_q;
    logic        err_q;
    logic [3:0]  code_q;
    logic        srq_en_q;
    logic        powerup_q;
    logic        pon_arm_q;
    logic        sum_prev_q;
    logic [4:0]  test_res_q;
    logic        test_q;
    logic        own_bus_q;
    logic        clr_pend_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic        req_w;
    logic        acc_w;
    logic        wr_acc_w;
    logic        rd_acc_w;
    logic        be0_w;
    logic        hit_ctrl_w;
    logic        hit_test_w;
    logic        start_reinit_w;
    logic        start_test_w;
    logic        take_clr_w;
    logic        start_w;
    logic        done_w;
    logic [31:0] rd_mux_w;

    assign req_w    = avs_read_i | avs_write_i;
    assign acc_w    = (state_q == SFSR_ACK) && req_w;
    assign wr_acc_w = acc_w && avs_write_i;
    assign rd_acc_w = acc_w && avs_read_i;
    assign be0_w    = avs_byteenable_i[0];

    assign hit_ctrl_w = avs_address_i == `SFSR_OFF_CTRL;
    assign hit_test_w = avs_address_i == `SFSR_OFF_TEST;

    assign take_clr_w = (state_q == SFSR_IDLE) && clr_pend_q;
    assign start_reinit_w = take_clr_w ||
        ((state_q == SFSR_IDLE) && avs_write_i && hit_ctrl_w && be0_w &&
         avs_writedata_i[`SFSR_CTRL_REINIT]);
    assign start_test_w = !take_clr_w && (state_q == SFSR_IDLE) &&
        avs_write_i && hit_test_w && be0_w;
    assign start_w = start_reinit_w | start_test_w;

    // ----------------------------------------
    // live conditions and fault events
    // ----------------------------------------
    sfsr_cond_t live_w;
    sfsr_cond_t fset_w;
    sfsr_cond_t fclr_w;
    sfsr_cond_t sticky_d;
    sfsr_cond_t enable_d;
    sfsr_cond_t fault_d;
    logic       sum_w;
    logic       sticky_ld_w;
    logic       fault_rd_w;
    logic       enable_wr_w;
    logic [7:0] spoll_w;

    // programming fault bit comes from the parser, never from the mask
    assign live_w = {cond_i[8], err_q, cond_i[6:0]};

    // mask or condition change both qualify, so enabling late still fires
    assign fset_w = live_w & enable_q &
                    ~(live_prev_q & enable_prev_q);

    assign sticky_ld_w = rd_acc_w &&
                         avs_address_i == `SFSR_OFF_STICKY;
    assign sticky_d    = sticky_ld_w ? live_w
                                     : sticky_q | live_w;

    // only bits the answer carried are cleared
    assign fault_rd_w = rd_acc_w &&
                        avs_address_i == `SFSR_OFF_FAULT;
    assign fclr_w  = fault_rd_w ? avs_readdata_o[8:0] : '0;
    assign fault_d = (fault_q & ~fclr_w) | fset_w;

    // weight sum equals the binary value; any name order ors the same bits
    assign enable_wr_w = wr_acc_w &&
                         avs_address_i == `SFSR_OFF_ENABLE;
    assign enable_d = {avs_byteenable_i[1] ? avs_writedata_i[8]
                                           : enable_q[8],
                       be0_w ? avs_writedata_i[7:0]
                             : enable_q[7:0]};

    assign sum_w = |fault_q;

    assign spoll_w = (8'h01 << `SFSR_SP_RQS) & {8{srq_o}} |
                     (8'h01 << `SFSR_SP_SUMMARY) & {8{sum_w}} |
                     (8'h01 << `SFSR_SP_PROG) & {8{err_q}} |
                     (8'h01 << `SFSR_SP_POWERUP) & {8{powerup_q}};

    // ----------------------------------------
    // read data
    // ----------------------------------------
    assign rd_mux_w =
        (avs_address_i == `SFSR_OFF_LIVE)   ? {23'h0, live_w}   :
        (avs_address_i == `SFSR_OFF_STICKY) ? {23'h0, sticky_q | live_w} :
        (avs_address_i == `SFSR_OFF_ENABLE) ? {23'h0, enable_q} :
        (avs_address_i == `SFSR_OFF_FAULT)  ? {23'h0, fault_q}  :
        hit_ctrl_w ? {31'h0, srq_en_q}                          :
        (avs_address_i == `SFSR_OFF_SPOLL)  ? {24'h0, spoll_w}  :
        (avs_address_i == `SFSR_OFF_CODE)   ? {28'h0, code_q}   :
        hit_test_w ? {23'h0, test_subset_o, 3'h0, test_res_q}   :
        32'h0;

    // ----------------------------------------
    // handshake sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SFSR_IDLE: begin
                if (start_w) begin
                    state_d = SFSR_SETTLE;
                end else if (req_w) begin
                    state_d = SFSR_ACK;
                end
            end
            SFSR_SETTLE: begin
                // bus write stays stalled until circuits settle
                if (done_w) begin
                    state_d = own_bus_q ? SFSR_ACK : SFSR_IDLE;
                end
            end
            SFSR_ACK: begin
                state_d = SFSR_IDLE;
            end
            default: begin
                state_d = SFSR_IDLE;
            end
        endcase
    end

    sfsr_settle_timer #(
        .CYC (SETTLE_CYC)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .start_i    (start_w),
        .done_o     (done_w)
    );

    sfsr_char_guard u_guard (
        .core_clk_i    (core_clk_i),
        .rstn_i        (rstn_i),
        .chr_valid_i   (chr_valid_i),
        .chr_data_i    (chr_data_i),
        .chr_eoi_i     (chr_eoi_i),
        .parse_fault_i (parse_fault_i),
        .chr_valid_o   (chr_valid_o),
        .chr_data_o    (chr_data_o),
        .flush_o       (flush_o)
    );

    // ----------------------------------------
    // bus side flops
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q           <= SFSR_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
            own_bus_q         <= 1'b0;
            clr_pend_q        <= 1'b0;
        end else begin
            state_q           <= state_d;
            avs_waitrequest_o <= state_d != SFSR_ACK;
            if (state_d == SFSR_ACK) begin
                avs_readdata_o <= rd_mux_w;
            end
            if (start_w) begin
                own_bus_q <= !take_clr_w;
            end
            clr_pend_q <= dev_clear_i | (clr_pend_q & ~take_clr_w);
        end
    end

    // ----------------------------------------
    // status and fault registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sticky_q      <= '0;
            enable_q      <= `SFSR_ENABLE_RST;
            fault_q       <= '0;
            live_prev_q   <= '0;
            enable_prev_q <= `SFSR_ENABLE_RST;
            sum_prev_q    <= 1'b0;
        end else if (start_reinit_w) begin
            // presets live elsewhere and are untouched here
            sticky_q      <= live_w;
            enable_q      <= `SFSR_ENABLE_RST;
            fault_q       <= '0;
            live_prev_q   <= live_w;
            enable_prev_q <= `SFSR_ENABLE_RST;
            sum_prev_q    <= 1'b0;
        end else begin
            sticky_q      <= sticky_d;
            enable_q      <= enable_wr_w ? enable_d : enable_q;
            fault_q       <= fault_d;
            live_prev_q   <= live_w;
            enable_prev_q <= enable_q;
            sum_prev_q    <= sum_w;
        end
    end

    // ----------------------------------------
    // programming fault code
    // ----------------------------------------
    logic code_rd_w;
    assign code_rd_w = rd_acc_w && avs_address_i == `SFSR_OFF_CODE;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_q  <= 1'b0;
            code_q <= `SFSR_CODE_NONE;
        end else if (start_reinit_w) begin
            err_q  <= 1'b0;
            code_q <= `SFSR_CODE_NONE;
        end else if (talk_no_query_i) begin
            err_q  <= 1'b1;
            code_q <= `SFSR_CODE_NOQUERY;
        end else if (parse_fault_i) begin
            // codes 1..7 are classified by the parser
            err_q  <= 1'b1;
            code_q <= parse_code_i;
        end else if (code_rd_w) begin
            err_q  <= 1'b0;
        end
    end

    // ----------------------------------------
    // service request
    // ----------------------------------------
    logic srq_set_w;
    logic srq_clr_w;
    logic ctrl_wr_w;

    assign ctrl_wr_w = wr_acc_w && hit_ctrl_w && be0_w;
    assign srq_set_w = (srq_en_q && sum_w && !sum_prev_q)
                     || (pon_arm_q && pon_srq_sw_i);
    assign srq_clr_w = rd_acc_w &&
                       avs_address_i == `SFSR_OFF_SPOLL;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            srq_en_q  <= 1'b0;
            powerup_q <= 1'b1;
            pon_arm_q <= 1'b1;
            srq_o     <= 1'b0;
        end else if (start_reinit_w) begin
            srq_en_q  <= 1'b0;
            powerup_q <= 1'b0;
            pon_arm_q <= 1'b0;
            srq_o     <= 1'b0;
        end else begin
            if (ctrl_wr_w) begin
                srq_en_q <= avs_writedata_i[`SFSR_CTRL_SRQ_EN];
            end
            // switch sampled once, first edge after reset release
            pon_arm_q <= 1'b0;
            srq_o     <= srq_set_w | (srq_o & ~srq_clr_w);
        end
    end

    // ----------------------------------------
    // self test and panel
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            test_q        <= 1'b0;
            test_run_o    <= 1'b0;
            test_subset_o <= 1'b0;
            test_res_q    <= 5'h00;
            fault_led_o   <= 1'b0;
            reinit_o      <= 1'b0;
        end else begin
            if (start_test_w) begin
                test_q        <= 1'b1;
                test_run_o    <= 1'b1;
                test_subset_o <= out_en_i;
            end else if (start_reinit_w) begin
                reinit_o <= 1'b1;
            end else if (done_w) begin
                if (test_q) begin
                    test_res_q <= test_code_i;
                end
                test_q     <= 1'b0;
                test_run_o <= 1'b0;
                reinit_o   <= 1'b0;
            end
            fault_led_o <= live_w[`SFSR_COND_PROG];
        end
    end

endmodule : sfsr_status_fault

// ### bench/sfsr_status_fault_chk.sv
/*
 * port checker for the status/fault block, bound to its top module.
 * assumes one clock domain and the active-low asynchronous reset.
 */
`timescale 1ns/10ps
module sfsr_status_fault_chk #(
    parameter int SETTLE_CYC = 20
) (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    // driven inputs
    input  wire logic       avs_read_i,
    input  wire logic       chr_valid_i,
    input  wire logic [7:0] chr_data_i,
    input  wire logic       chr_eoi_i,
    input  wire logic       parse_fault_i,
    // watched outputs
    input  wire logic       avs_waitrequest_o,
    input  wire logic       chr_valid_o,
    input  wire logic [7:0] chr_data_o,
    input  wire logic       flush_o,
    input  wire logic       fault_led_o,
    input  wire logic       srq_o,
    input  wire logic       reinit_o,
    input  wire logic       test_run_o,
    input  wire logic       test_subset_o
);
    // generous ceiling, three times the fixed settle length plus eight
    localparam int MAXW = 3 * SETTLE_CYC + 8;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_fault_char;
        parse_fault_i ##1 (chr_valid_i && !chr_eoi_i && chr_data_i != 8'h0A);
    endsequence
    sequence s_settle_start;
        $rose(reinit_o) ##1 reinit_o;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_FLUSH: assert property (parse_fault_i |=> flush_o)
        else $error("no flush after parse fault");
    AST_DROP: assert property (s_fault_char |=> !chr_valid_o)
        else $error("character passed while discarding");
    AST_PASS: assert property (chr_valid_o |-> $past(chr_valid_i) &&
        chr_data_o == $past(chr_data_i)) else $error("character copy mismatch");
    AST_LED: assert property (parse_fault_i |-> ##2 fault_led_o)
        else $error("fault lamp not lit");
    AST_WAIT: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_ANS: assert property ($rose(avs_read_i) |=> !avs_waitrequest_o)
        else $error("read not answered next cycle");
    AST_SETTLE_MIN: assert property (s_settle_start |-> reinit_o [*6])
        else $error("clear settle too short");
    AST_SETTLE_MAX: assert property ($rose(reinit_o) |-> ##[1:MAXW] !reinit_o)
        else $error("clear settle never ends");
    AST_CLEAR: assert property (s_settle_start ##1 reinit_o |-> !srq_o && !fault_led_o)
        else $error("request or lamp kept over clear");
    AST_SUBSET: assert property (test_run_o [*2] |-> $stable(test_subset_o))
        else $error("test subset changed mid test");
endmodule : sfsr_status_fault_chk

bind sfsr_status_fault sfsr_status_fault_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
    .core_clk_i, .rstn_i, .avs_read_i, .chr_valid_i, .chr_data_i, .chr_eoi_i,
    .parse_fault_i, .avs_waitrequest_o, .chr_valid_o, .chr_data_o, .flush_o,
    .fault_led_o, .srq_o, .reinit_o, .test_run_o, .test_subset_o);

// ### bench/sfsr_ctl_model.sv
/*
 * bus controller model: avalon-mm master for queries, command characters
 * and talk addressing. assumes waitrequest stays high while the slave idles.
 */
`timescale 1ns/10ps
module sfsr_ctl_model (
    // clock
    input  wire logic  core_clk_i,
    // avalon-mm master
    input  wire logic  avs_waitrequest_i,
    output logic [4:0]  avs_address_o,
    output logic        avs_read_o,
    output logic        avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0]  avs_byteenable_o,
    // command link
    output logic        chr_valid_o,
    output logic [7:0]  chr_data_o,
    output logic        chr_eoi_o,
    output logic        talk_no_query_o
);
    initial begin
        {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
        avs_byteenable_o = 4'hF;
        {chr_valid_o, chr_data_o, chr_eoi_o, talk_no_query_o} = '0;
    end
    task automatic acc(input logic we, input logic [4:0] a, input logic [31:0] d);
        avs_address_o <= a;
        avs_writedata_o <= d;
        avs_read_o <= !we;
        avs_write_o <= we;
        do @(posedge core_clk_i); while (avs_waitrequest_i !== 1'b0);
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        // idle edge so the next request is not raised in the same step
        @(posedge core_clk_i);
    endtask : acc
    task automatic send_chr(input logic [7:0] c, input logic e);
        chr_valid_o <= 1'b1;
        chr_data_o <= c;
        chr_eoi_o <= e;
        @(posedge core_clk_i);
        chr_valid_o <= 1'b0;
        chr_eoi_o <= 1'b0;
        chr_data_o <= ~c;
        @(posedge core_clk_i);
    endtask : send_chr
    task automatic talk();
        talk_no_query_o <= 1'b1;
        @(posedge core_clk_i);
        talk_no_query_o <= 1'b0;
    endtask : talk
endmodule : sfsr_ctl_model

// ### bench/sfsr_status_fault_tb_top.sv
/*
 * self-checking bench for the status/fault block.
 * assumes the controller model and the bound port checker.
 */
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module sfsr_status_fault_tb_top;
    import sfsr_pkg::*;
    localparam int SC = 20;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  adr;
    logic [31:0] wd, rdat;
    logic [3:0]  be;
    logic        rd, wr, wreq, cv, ce, tnq, cvo, fled, srq, rin;
    logic [7:0]  cd, cdo;
    sfsr_cond_t  cond = 9'h000;
    sfsr_cond_t  c;
    logic        oen = 1'b0, powerup_flag = 1'b1;
    logic        dclr = 1'b0, pf = 1'b0;
    logic [3:0]  pcode = 4'h0;
    logic [4:0]  tcode = 5'h00;
    logic [31:0] rq[$];
    logic [7:0]  cq[$];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0, t0;

    always #10 clk = ~clk;

    sfsr_status_fault #(.SETTLE_CYC(SC)) dut (
        .core_clk_i(clk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cond_i(cond),
        .out_en_i(oen), .pon_srq_sw_i(powerup_flag), .dev_clear_i(dclr), .chr_valid_i(cv),
        .chr_data_i(cd), .chr_eoi_i(ce), .parse_fault_i(pf), .parse_code_i(pcode),
        .talk_no_query_i(tnq), .chr_valid_o(cvo), .chr_data_o(cdo), .flush_o(),
        .test_code_i(tcode), .test_run_o(), .test_subset_o(), .srq_o(srq),
        .fault_led_o(fled), .reinit_o(rin));

    sfsr_ctl_model u_ctl (
        .core_clk_i(clk), .avs_waitrequest_i(wreq), .avs_address_o(adr),
        .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wd),
        .avs_byteenable_o(be), .chr_valid_o(cv), .chr_data_o(cd), .chr_eoi_o(ce),
        .talk_no_query_o(tnq));

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rd && !wreq) begin
            chk(rdat, rq.pop_front());
        end
        if (cvo) begin
            chk({24'h0, cdo}, {24'h0, cq.pop_front()});
        end
        if (cyc > 4000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask : tk
    task automatic rdq(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        u_ctl.acc(1'b0, a, 32'h0);
    endtask : rdq
    task automatic pfault(input logic [3:0] k);
        pf <= 1'b1;
        pcode <= k;
        @(posedge clk);
        pf <= 1'b0;
    endtask : pfault

    initial begin
        void'($urandom(32'h5E246D35));
        tk(10);
        rstn <= 1'b1;
        tk(1);
        rdq(`SFSR_OFF_ENABLE, {23'h0, `SFSR_ENABLE_RST});
        rdq(`SFSR_OFF_CTRL, 32'h0);
        rdq(`SFSR_OFF_SPOLL, 32'h42);
        rdq(`SFSR_OFF_CODE, {28'h0, `SFSR_CODE_NONE});
        c = 9'($urandom()) & 9'h16A | 9'h002;
        cond <= c;
        tk(3);
        rdq(`SFSR_OFF_LIVE, {23'h0, c});
        rdq(5'h02, 32'h0);
        rdq(`SFSR_OFF_STICKY, {23'h0, c});
        cond <= c | 9'h010;
        tk(1);
        cond <= c;
        tk(2);
        rdq(`SFSR_OFF_STICKY, {23'h0, c | 9'h010});
        rdq(`SFSR_OFF_STICKY, {23'h0, c});
        u_ctl.acc(1'b1, `SFSR_OFF_CTRL, 32'h1);
        rdq(`SFSR_OFF_CTRL, 32'h1);
        u_ctl.acc(1'b1, `SFSR_OFF_ENABLE, 32'd134);
        rdq(`SFSR_OFF_ENABLE, 32'd134);
        tk(2);
        chk({31'h0, srq}, 32'h1);
        rdq(`SFSR_OFF_SPOLL, 32'h4A);
        chk({31'h0, srq}, 32'h0);
        rdq(`SFSR_OFF_FAULT, {23'h0, c & 9'h086});
        fork
            rdq(`SFSR_OFF_FAULT, 32'h0);
            begin
                tk(1);
                cond <= c | 9'h004;
            end
        join
        tk(3);
        chk({31'h0, srq}, 32'h1);
        rdq(`SFSR_OFF_FAULT, 32'h4);
        u_ctl.acc(1'b1, `SFSR_OFF_ENABLE, 32'h0);
        cond <= c | 9'h005;
        tk(3);
        rdq(`SFSR_OFF_FAULT, 32'h0);
        rdq(`SFSR_OFF_LIVE, {23'h0, c | 9'h005});
        cq.push_back(8'h41);
        u_ctl.send_chr(8'h41, 1'b0);
        pfault(4'h1);
        u_ctl.send_chr(8'h43, 1'b0);
        u_ctl.send_chr(8'h0A, 1'b0);
        cq.push_back(8'h45);
        u_ctl.send_chr(8'h45, 1'b1);
        for (int k = 1; k < 8; k++) begin
            pfault(4'(k));
            tk(3);
            chk({31'h0, fled}, 32'h1);
            rdq(`SFSR_OFF_LIVE, {23'h0, c | 9'h085});
            rdq(`SFSR_OFF_CODE, 32'(k));
        end
        u_ctl.talk();
        tk(3);
        rdq(`SFSR_OFF_CODE, {28'h0, `SFSR_CODE_NOQUERY});
        oen <= 1'($urandom());
        tcode <= 5'($urandom());
        tk(1);
        u_ctl.acc(1'b1, `SFSR_OFF_TEST, 32'h1);
        rdq(`SFSR_OFF_TEST, {23'h0, oen, 3'h0, tcode});
        u_ctl.acc(1'b1, `SFSR_OFF_ENABLE, 32'h1FF);
        t0 = cyc;
        u_ctl.acc(1'b1, `SFSR_OFF_CTRL, 32'h2);
        chk(32'(cyc - t0 >= SC), 32'h1);
        rdq(`SFSR_OFF_ENABLE, 32'h0);
        rdq(`SFSR_OFF_CTRL, 32'h0);
        rdq(`SFSR_OFF_SPOLL, 32'h0);
        u_ctl.acc(1'b1, `SFSR_OFF_ENABLE, 32'h1FF);
        dclr <= 1'b1;
        tk(1);
        dclr <= 1'b0;
        tk(SC + 5);
        rdq(`SFSR_OFF_ENABLE, 32'h0);
        complete_run();
    end
endmodule : sfsr_status_fault_tb_top
